//--- rtl/cld_lock_detector.sv
// Functional notes
// [R1] Error over 1000 ppm raises loss of lock and starts acquisition.
// [R2] Each acquisition resets the oscillator to its 10 MHz floor, sweeps up.
// [R3] Sweep uses large steps first, smaller steps near the target.
// [R4] Loss of lock clears within 250 ppm; between 250 and 1000 it holds.
// [R5] On lock, frequency loop turns off and phase/delay loops turn on.
// [R6] Normal mode compares oscillator directly against the data rate.
// [R7] Control A bit 0 selects lock-to-reference mode.
// [R8] Software sets reference range bits 7:6 and divide ratio bits 5:2.
// [R9] Reference mode compares against the divided reference, same hysteresis.
// [R10] Sticky lock-loss bit 4 of status sets on any lock loss.
// [R11] Writing 1 then 0 to control B bit 6 clears the sticky bit.
// [R12] Control B bit 7 makes the lock pin mirror the sticky bit.
// [R13] A drop to a lower harmonic forces loss of lock and reacquisition.
// [R14] A higher harmonic is caught as an ordinary frequency error.
// [R15] Harmonic check finishes within 16384 locked-rate bit periods.
// [R16] Harmonic detector is off in lock-to-reference mode.
// [R17] Signal-absent output is high while amplitude is below threshold.
// [R18] Control C bit 2 inverts the signal-absent output.
// [R19] Frequencies are compared by counting edges over a fixed window.
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module cld_lock_detector #(
    parameter int WIN = cld_pkg::WIN_CYCLES
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    input wire logic data_pin,
    input wire logic osc_pin,
    input wire logic acquisition_reference_clock,
    input wire logic signal_low_pin,
    output logic lock_lost_flag,
    output logic signal_absent_flag,
    output logic [15:0] osc_code,
    output logic fll_enable,
    output logic pll_dll_enable,
    output logic irq
);
    // ==========================================================
    // Pin synchronisers; stage one feeds stage two only
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            sync3 <= 4'h0;
        end else if (ce) begin
            sync1 <= {signal_low_pin, acquisition_reference_clock,
                      osc_pin, data_pin};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Edge detection looks only at the second and third stages
    wire data_edge = sync2[0] ^ sync3[0];
    wire osc_tick = sync2[1] && !sync3[1];
    wire ref_tick = sync2[2] && !sync3[2];
    wire los_live = sync2[3];
    wire los_rise = sync2[3] && !sync3[3];

    // ==========================================================
    // Control and status registers
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] ctrl_c;
    logic [cld_pkg::IRQ_W-1:0] irq_stat;
    logic [cld_pkg::IRQ_W-1:0] irq_mask;
    logic sticky;
    logic live_lol;
    cld_pkg::cld_state_t state;
    cld_pkg::cld_state_t next_state;

    // Write decode
    wire wr_a = wr_stb && addr == cld_pkg::ADDR_CTRL_A;
    wire wr_b = wr_stb && addr == cld_pkg::ADDR_CTRL_B;
    wire wr_c = wr_stb && addr == cld_pkg::ADDR_CTRL_C;
    wire wr_stat = wr_stb && addr == cld_pkg::ADDR_IRQ_STAT;
    wire wr_mask = wr_stb && addr == cld_pkg::ADDR_IRQ_MASK;

    // Mode fields
    wire ref_mode = ctrl_a[cld_pkg::CA_REF_MODE]; // R7
    wire [3:0] div_field = ctrl_a[cld_pkg::CA_DIV_LSB +: 4]; // R8
    wire [1:0] range_field = ctrl_a[cld_pkg::CA_RANGE_LSB +: 2]; // R8
    // Changing the lock source invalidates the current lock
    wire mode_change = wr_a &&
        (wdata[cld_pkg::CA_REF_MODE] != ref_mode);

    // Sticky clear fires on the 1-to-0 write of the clear bit
    wire sticky_clr = wr_b && ctrl_b[cld_pkg::CB_STICKY_CLR] &&
        !wdata[cld_pkg::CB_STICKY_CLR]; // R11

    // ==========================================================
    // Frequency measurement
    // Normal mode: data edges weighted for one transition per two bits
    wire [7:0] ref_weight = 8'({4'h0, div_field} + 8'h01) << range_field;
    wire [7:0] tgt_weight = ref_mode ? ref_weight : // R9
        cld_pkg::NORMAL_WEIGHT; // R6
    wire tgt_tick = ref_mode ? ref_tick : data_edge; // R6 R9
    cld_pkg::cld_meas_t meas;

    cld_freq_meter #(
        .WIN(WIN)
    ) u_meter (
        .clock(clock),
        .sys_rst(sys_rst),
        .ce(ce),
        .osc_tick(osc_tick),
        .tgt_tick(tgt_tick),
        .tgt_weight(tgt_weight),
        .meas(meas)
    );

    wire [cld_pkg::TGT_W-1:0] osc_full =
        cld_pkg::TGT_W'(meas.osc_cnt);
    wire [cld_pkg::TGT_W-1:0] freq_err =
        cld_pkg::abs_diff(osc_full, meas.tgt_cnt);
    wire out_250 = cld_pkg::beyond_ppm(freq_err, meas.tgt_cnt,
        cld_pkg::LOCK_PPM); // R4
    wire out_1000 = cld_pkg::beyond_ppm(freq_err, meas.tgt_cnt,
        cld_pkg::UNLOCK_PPM); // R1
    wire osc_low = osc_full < meas.tgt_cnt;

    // Step shrinks as the error falls below 1/8 and 1/64 of target
    wire err_big = {freq_err, 3'b000} > {3'b000, meas.tgt_cnt};
    wire err_mid = {freq_err, 6'h00} > {6'h00, meas.tgt_cnt};
    wire [15:0] step = err_big ? cld_pkg::OSC_STEP_BIG :
        (err_mid ? cld_pkg::OSC_STEP_MID : cld_pkg::OSC_STEP_FINE); // R3
    // Saturate at the top of the range rather than wrap to the floor
    wire [15:0] osc_up = (osc_code > 16'hffff - step) ? 16'hffff :
        osc_code + step;
    wire [15:0] osc_down = (osc_code == 16'h0000) ? 16'h0000 :
        osc_code - 16'h0001;

    // ==========================================================
    // Harmonic detector, held off in reference mode
    logic harm_hit;
    wire harm_en = !ref_mode && state == cld_cd_track(); // R16

    function automatic cld_pkg::cld_state_t cld_cd_track();
        return cld_pkg::CLD_TRACK;
    endfunction : cld_cd_track

    cld_harmonic_det u_harm (
        .clock(clock),
        .sys_rst(sys_rst),
        .ce(ce),
        .enable(harm_en),
        .osc_tick(osc_tick),
        .data_edge(data_edge),
        .hit(harm_hit)
    );

    // ==========================================================
    // Acquisition sequencer
    // A higher harmonic needs no special path: it shows as a large error
    always_comb begin
        next_state = state;
        case (state)
            cld_pkg::CLD_RESTART: begin
                next_state = cld_pkg::CLD_SWEEP; // R2
            end
            cld_pkg::CLD_SWEEP: begin
                if (mode_change) begin
                    next_state = cld_pkg::CLD_RESTART;
                end else if (meas.valid && !out_250) begin
                    next_state = cld_pkg::CLD_TRACK; // R4
                end
            end
            cld_pkg::CLD_TRACK: begin
                if (meas.valid && out_1000) begin
                    next_state = cld_pkg::CLD_RESTART; // R1 R14
                end else if (harm_hit || mode_change) begin
                    next_state = cld_pkg::CLD_RESTART; // R13
                end
            end
            default: begin
                next_state = cld_pkg::CLD_RESTART;
            end
        endcase
    end

    // Lock is lost whenever the tracking state is left
    wire loss_evt = state == cld_pkg::CLD_TRACK &&
        next_state != cld_pkg::CLD_TRACK; // R10
    wire gain_evt = state != cld_pkg::CLD_TRACK &&
        next_state == cld_pkg::CLD_TRACK;
    wire next_lol = next_state != cld_pkg::CLD_TRACK;

    // Oscillator code: floor on restart, climb or trim while sweeping
    wire sweep_step = state == cld_pkg::CLD_SWEEP && meas.valid && out_250;
    wire [15:0] next_osc =
        (state == cld_pkg::CLD_RESTART) ? cld_pkg::OSC_CODE_BOTTOM : // R2
        (sweep_step ? (osc_low ? osc_up : osc_down) : osc_code); // R3

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state <= cld_pkg::CLD_RESTART;
            live_lol <= 1'b1;
            fll_enable <= 1'b1;
            pll_dll_enable <= 1'b0;
            osc_code <= cld_pkg::OSC_CODE_BOTTOM;
        end else if (ce) begin
            state <= next_state;
            live_lol <= next_lol; // R1 R4
            fll_enable <= next_lol; // R5
            pll_dll_enable <= !next_lol; // R5
            osc_code <= next_osc;
        end
    end

    // ==========================================================
    // Sticky lock loss; a loss in the clearing cycle wins
    wire next_sticky = loss_evt || (sticky && !sticky_clr); // R10 R11

    // Interrupt status is write-one-to-clear, new events win
    wire [cld_pkg::IRQ_W-1:0] irq_evt = {los_rise, harm_hit && harm_en,
        gain_evt, loss_evt};
    wire [cld_pkg::IRQ_W-1:0] irq_w1c = wr_stat ?
        wdata[cld_pkg::IRQ_W-1:0] : '0;
    wire [cld_pkg::IRQ_W-1:0] next_irq_stat = (irq_stat & ~irq_w1c) | irq_evt;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_a <= cld_pkg::CTRL_RST;
            ctrl_b <= cld_pkg::CTRL_RST;
            ctrl_c <= cld_pkg::CTRL_RST;
            irq_mask <= cld_pkg::IRQ_RST;
            irq_stat <= cld_pkg::IRQ_RST;
            sticky <= 1'b0;
        end else if (ce) begin
            if (wr_a) begin
                ctrl_a <= wdata;
            end
            if (wr_b) begin
                ctrl_b <= wdata;
            end
            if (wr_c) begin
                ctrl_c <= wdata;
            end
            if (wr_mask) begin
                irq_mask <= wdata[cld_pkg::IRQ_W-1:0];
            end
            irq_stat <= next_irq_stat;
            sticky <= next_sticky;
        end
    end

    // ==========================================================
    // Pins and read port
    wire next_lock_pin = ctrl_b[cld_pkg::CB_PIN_STICKY] ? sticky :
        live_lol; // R12
    wire next_los_pin = los_live ^ ctrl_c[cld_pkg::CC_LOS_INV]; // R17 R18
    wire [7:0] misc_rd = {3'b000, sticky, 1'b0,
        state == cld_pkg::CLD_TRACK, los_live, live_lol};
    wire [7:0] read_mux =
        (addr == cld_pkg::ADDR_CTRL_A) ? ctrl_a :
        (addr == cld_pkg::ADDR_CTRL_B) ? ctrl_b :
        (addr == cld_pkg::ADDR_CTRL_C) ? ctrl_c :
        (addr == cld_pkg::ADDR_MISC) ? misc_rd :
        (addr == cld_pkg::ADDR_IRQ_STAT) ? {4'h0, irq_stat} :
        (addr == cld_pkg::ADDR_IRQ_MASK) ? {4'h0, irq_mask} :
        (addr == cld_pkg::ADDR_OSC_LO) ? osc_code[7:0] :
        (addr == cld_pkg::ADDR_OSC_HI) ? osc_code[15:8] : 8'h00;

    // Read data stands one cycle only, zero otherwise
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdata <= 8'h00;
            lock_lost_flag <= 1'b1;
            signal_absent_flag <= 1'b0;
            irq <= 1'b0;
        end else if (ce) begin
            rdata <= rd_stb ? read_mux : 8'h00;
            lock_lost_flag <= next_lock_pin;
            signal_absent_flag <= next_los_pin;
            irq <= |(next_irq_stat & irq_mask);
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    lol_on_error_a: assert property ( // R1
        ce && state == cld_pkg::CLD_TRACK && meas.valid && out_1000
        |=> live_lol && state == cld_pkg::CLD_RESTART)
        else $error("lock loss not raised on large error");

    sweep_floor_a: assert property ( // R2
        ce && state == cld_pkg::CLD_RESTART
        |=> osc_code == cld_pkg::OSC_CODE_BOTTOM &&
            state == cld_pkg::CLD_SWEEP)
        else $error("acquisition did not start at the floor");

    release_bound_a: assert property ( // R4
        $fell(live_lol) |-> $past(meas.valid) && !$past(out_250))
        else $error("lock released outside 250 ppm");

    loops_swap_a: assert property ( // R5
        fll_enable == (state != cld_pkg::CLD_TRACK) &&
        pll_dll_enable == !fll_enable)
        else $error("frequency and phase loops both on or off");

    sticky_set_a: assert property ( // R10
        ce && loss_evt |=> sticky ##1 (sticky || $past(ce && sticky_clr)))
        else $error("sticky lock loss not held");

    sticky_clear_a: assert property ( // R11
        ce && sticky_clr && !loss_evt |=> !sticky)
        else $error("sticky lock loss not cleared");

    pin_select_a: assert property ( // R12
        ce |=> lock_lost_flag == ($past(ctrl_b[cld_pkg::CB_PIN_STICKY]) ?
            $past(sticky) : $past(live_lol)))
        else $error("lock pin shows wrong source");

    harm_restart_a: assert property ( // R13
        ce && harm_hit && state == cld_pkg::CLD_TRACK |=> live_lol)
        else $error("harmonic did not force reacquisition");

    harm_off_a: assert property ( // R16
        ref_mode && $past(ref_mode) |-> !harm_hit)
        else $error("harmonic hit in reference mode");

    los_polarity_a: assert property ( // R17 R18
        ce |=> signal_absent_flag ==
            ($past(los_live) ^ $past(ctrl_c[cld_pkg::CC_LOS_INV])))
        else $error("signal absent output polarity wrong");

endmodule : cld_lock_detector
`default_nettype wire

//--- rtl/cld_pkg.sv
package cld_pkg;

    // ==========================================================
    // Widths and counts
    localparam int CNT_W = 24;
    localparam int TGT_W = 32;
    localparam int WIN_CYCLES = 1048576;
    localparam int HARM_BITS = 16384;
    localparam int LOCK_PPM = 250;
    localparam int UNLOCK_PPM = 1000;
    localparam int PPM_SCALE = 1000000;
    localparam logic [7:0] NORMAL_WEIGHT = 8'h02;

    // ==========================================================
    // Oscillator coarse code; code zero is the 10 MHz floor
    localparam logic [15:0] OSC_CODE_BOTTOM = 16'h0000;
    localparam logic [15:0] OSC_STEP_BIG = 16'h0100;
    localparam logic [15:0] OSC_STEP_MID = 16'h0010;
    localparam logic [15:0] OSC_STEP_FINE = 16'h0001;

    // ==========================================================
    // Register offsets, field positions and reset values
    localparam logic [3:0] ADDR_CTRL_A = 4'h0;
    localparam logic [3:0] ADDR_CTRL_B = 4'h1;
    localparam logic [3:0] ADDR_CTRL_C = 4'h2;
    localparam logic [3:0] ADDR_MISC = 4'h3;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
    localparam logic [3:0] ADDR_OSC_LO = 4'h6;
    localparam logic [3:0] ADDR_OSC_HI = 4'h7;
    localparam int CA_REF_MODE = 0;
    localparam int CA_DIV_LSB = 2;
    localparam int CA_RANGE_LSB = 6;
    localparam int CB_STICKY_CLR = 6;
    localparam int CB_PIN_STICKY = 7;
    localparam int CC_LOS_INV = 2;
    localparam int MISC_STICKY = 4;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [3:0] IRQ_RST = 4'h0;
    // Interrupt bits: lock lost, lock gained, harmonic, signal lost
    localparam int IRQ_W = 4;

    typedef struct packed {
        logic valid;
        logic [CNT_W-1:0] osc_cnt;
        logic [TGT_W-1:0] tgt_cnt;
    } cld_meas_t;

    typedef enum logic [1:0] {
        CLD_RESTART,
        CLD_SWEEP,
        CLD_TRACK
    } cld_state_t;

    function automatic logic [TGT_W-1:0] abs_diff(
        input logic [TGT_W-1:0] a,
        input logic [TGT_W-1:0] b
    );
        return (a > b) ? a - b : b - a;
    endfunction : abs_diff

    // True when err / tgt exceeds ppm parts per million
    function automatic logic beyond_ppm(
        input logic [TGT_W-1:0] err,
        input logic [TGT_W-1:0] tgt,
        input int ppm
    );
        logic [63:0] lhs;
        logic [63:0] rhs;
        lhs = {32'h0, err} * 64'(PPM_SCALE);
        rhs = {32'h0, tgt} * 64'(ppm);
        return lhs > rhs;
    endfunction : beyond_ppm

endpackage : cld_pkg

//--- rtl/cld_freq_meter.sv
`timescale 1ns/100ps
`default_nettype none
module cld_freq_meter #(
    parameter int WIN = cld_pkg::WIN_CYCLES
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic osc_tick,
    input wire logic tgt_tick,
    input wire logic [7:0] tgt_weight,
    output cld_pkg::cld_meas_t meas
);
    logic [31:0] win_cnt;
    logic [cld_pkg::CNT_W-1:0] osc_acc;
    logic [cld_pkg::TGT_W-1:0] tgt_acc;
    wire win_end = (win_cnt == 32'(WIN - 1));
    wire [cld_pkg::CNT_W-1:0] osc_inc = osc_acc + cld_pkg::CNT_W'(osc_tick);
    wire [cld_pkg::TGT_W-1:0] tgt_inc =
        tgt_acc + (tgt_tick ? cld_pkg::TGT_W'(tgt_weight) : '0);

    // ==========================================================
    // Fixed window, both counts latched together at its end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            win_cnt <= '0;
            osc_acc <= '0;
            tgt_acc <= '0;
            meas <= '0;
        end else if (ce) begin
            win_cnt <= win_end ? '0 : win_cnt + 32'h1;
            osc_acc <= win_end ? '0 : osc_inc; // R19
            tgt_acc <= win_end ? '0 : tgt_inc; // R19
            meas <= '{valid: win_end, osc_cnt: osc_inc, tgt_cnt: tgt_inc};
        end
    end
endmodule : cld_freq_meter
`default_nettype wire

//--- rtl/cld_harmonic_det.sv
`timescale 1ns/100ps
`default_nettype none
module cld_harmonic_det (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic enable,
    input wire logic osc_tick,
    input wire logic data_edge,
    output logic hit
);
    logic [14:0] bit_cnt;
    logic [1:0] run;
    logic short_seen;
    logic edge_seen;
    wire win_end = osc_tick && (bit_cnt == 15'(cld_pkg::HARM_BITS - 1));

    // ==========================================================
    // A lower harmonic never shows a one-bit run at the locked rate
    always_ff @(posedge clock) begin
        if (sys_rst || !enable) begin
            bit_cnt <= '0;
            run <= 2'h0;
            short_seen <= 1'b0;
            edge_seen <= 1'b0;
            hit <= 1'b0;
        end else if (ce) begin
            if (osc_tick) begin
                bit_cnt <= win_end ? '0 : bit_cnt + 15'h1;
            end
            if (data_edge) begin
                run <= 2'h0;
            end else if (osc_tick && run != 2'h3) begin
                run <= run + 2'h1;
            end
            short_seen <= !win_end &&
                (short_seen || (data_edge && run <= 2'h1));
            edge_seen <= !win_end && (edge_seen || data_edge);
            hit <= win_end && edge_seen && !short_seen; // R15
        end
    end
endmodule : cld_harmonic_det
`default_nettype wire

//--- bench/cld_front_end.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Optical front end: serial NRZ data and amplitude comparator
module cld_front_end (
    input wire logic [7:0] bit_ns,
    input wire logic amp_low,
    output logic data_pin,
    output logic signal_low_pin
);
    // Runs of one and three bits keep density at 0.5 and include
    // single-bit runs, so steady data never looks like a harmonic
    initial begin
        data_pin = 1'b0;
        #1;
        forever begin
            #(bit_ns) data_pin = ~data_pin;
            #(3 * bit_ns) data_pin = ~data_pin;
        end
    end
    // Comparator level follows the commanded amplitude
    assign signal_low_pin = amp_low;
endmodule : cld_front_end
`default_nettype wire

//--- bench/cld_lock_detector_bench.sv
`timescale 1ns/100ps
`default_nettype none
module cld_lock_detector_bench;
    localparam int WIN = 16384;
    logic clock;
    logic sys_rst;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr_stb, rd_stb;
    logic [7:0] rdata;
    logic data_pin, osc_pin, ref_clk, signal_low_pin;
    logic lock_lost_flag, signal_absent_flag, fll_enable, pll_dll_enable;
    logic irq;
    logic [15:0] osc_code;
    logic [7:0] bit_ns;
    logic amp_low;
    logic [7:0] d;
    int n_errors;
    int tests_run;
    int cyc = 0;

    // ==========================================================
    // Design, front end and clocks
    cld_lock_detector #(.WIN(WIN)) dut (
        .clock(clock), .sys_rst(sys_rst), .ce(1'b1), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .data_pin(data_pin), .osc_pin(osc_pin),
        .acquisition_reference_clock(ref_clk),
        .signal_low_pin(signal_low_pin), .lock_lost_flag(lock_lost_flag),
        .signal_absent_flag(signal_absent_flag), .osc_code(osc_code),
        .fll_enable(fll_enable), .pll_dll_enable(pll_dll_enable),
        .irq(irq)
    );
    cld_front_end fe (
        .bit_ns(bit_ns), .amp_low(amp_low), .data_pin(data_pin),
        .signal_low_pin(signal_low_pin)
    );

    always #2 clock = ~clock;

    // Coarse oscillator: slow below code 0x100, on rate from there;
    // odd-ns edges keep sampling away from the clock edge
    initial begin
        osc_pin = 1'b0;
        #3;
        forever begin
            osc_pin = ~osc_pin;
            #((osc_code >= 16'h0100) ? 8 : 20);
        end
    end
    // Reference at half the edge rate of the locked oscillator
    initial begin
        ref_clk = 1'b0;
        #1;
        forever #16 ref_clk = ~ref_clk;
    end
    // Hang guard, about one window above the five windows the scenarios need
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            n_errors++;
            end_sim();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clock);
        addr <= a;
        wdata <= v;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : settle
    task automatic wait_lol(input logic lvl, input int lim);
        for (int i = 0; i < lim && lock_lost_flag !== lvl; i++)
            @(posedge clock);
        settle(2);
        chk("lock_lost_flag", {15'h0, lvl}, {15'h0, lock_lost_flag});
    endtask : wait_lol
    task end_sim;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim

    // ==========================================================
    // Scenarios
    task automatic t_reset;
        chk("lol", 16'h1, {15'h0, lock_lost_flag});
        chk("osc_code", 16'h0, osc_code);
        chk("fll", 16'h1, {15'h0, fll_enable});
        chk("pll", 16'h0, {15'h0, pll_dll_enable});
    endtask : t_reset
    // Control reset values, unmapped place refuses writes
    task automatic t_regs;
        logic [3:0] list [6] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h8, 4'ha};
        wr(4'ha, 8'hff);
        foreach (list[i]) begin
            rd(list[i]);
            chk("reg", 16'h0, {8'h0, d});
        end
    endtask : t_regs
    task automatic t_signal;
        @(posedge clock) amp_low <= 1'b1;
        settle(5);
        chk("sig_absent", 16'h1, {15'h0, signal_absent_flag});
        wr(cld_pkg::ADDR_CTRL_C, 8'h04);
        settle(2);
        chk("sig_absent", 16'h0, {15'h0, signal_absent_flag});
        @(posedge clock) amp_low <= 1'b0;
        settle(5);
        chk("sig_absent", 16'h1, {15'h0, signal_absent_flag});
        wr(cld_pkg::ADDR_CTRL_C, 8'h00);
        settle(2);
        chk("sig_absent", 16'h0, {15'h0, signal_absent_flag});
        // Event latched but masked, then unmasked, then cleared
        rd(cld_pkg::ADDR_IRQ_STAT);
        chk("irq_stat", 16'h8, {8'h0, d & 8'h08});
        chk("irq", 16'h0, {15'h0, irq});
        wr(cld_pkg::ADDR_IRQ_MASK, 8'h08);
        settle(2);
        chk("irq", 16'h1, {15'h0, irq});
        wr(cld_pkg::ADDR_IRQ_STAT, 8'h08);
        settle(2);
        chk("irq", 16'h0, {15'h0, irq});
    endtask : t_signal
    task automatic t_lock;
        wait_lol(1'b0, 3 * WIN);
        chk("osc_code", 16'h0100, osc_code);
        chk("fll", 16'h0, {15'h0, fll_enable});
        chk("pll", 16'h1, {15'h0, pll_dll_enable});
        rd(cld_pkg::ADDR_MISC);
        chk("misc", 16'h04, {8'h0, d & 8'h17});
    endtask : t_lock
    // Rate doubles: a higher harmonic is an ordinary loss
    task automatic t_lose;
        @(posedge clock) bit_ns <= 8'd8;
        wait_lol(1'b1, 2 * WIN + 200);
        chk("osc_code", 16'h0, osc_code);
        chk("fll", 16'h1, {15'h0, fll_enable});
        rd(cld_pkg::ADDR_MISC);
        chk("sticky", 16'h10, {8'h0, d & 8'h10});
        // Both the earlier gain and this loss are latched, masked off
        rd(cld_pkg::ADDR_IRQ_STAT);
        chk("irq_stat", 16'h3, {8'h0, d & 8'h03});
    endtask : t_lose
    task automatic t_sticky;
        wr(cld_pkg::ADDR_CTRL_B, 8'h80);
        settle(2);
        chk("pin", 16'h1, {15'h0, lock_lost_flag});
        wr(cld_pkg::ADDR_CTRL_B, 8'hc0);
        wr(cld_pkg::ADDR_CTRL_B, 8'h80);
        settle(2);
        rd(cld_pkg::ADDR_MISC);
        chk("sticky", 16'h0, {8'h0, d & 8'h10});
        chk("pin", 16'h0, {15'h0, lock_lost_flag});
        wr(cld_pkg::ADDR_CTRL_B, 8'h00);
        settle(2);
        chk("pin", 16'h1, {15'h0, lock_lost_flag});
    endtask : t_sticky
    // Reference mode, divide field 1, range 0: data rate ignored
    task automatic t_ref;
        wr(cld_pkg::ADDR_CTRL_A, 8'h05);
        rd(cld_pkg::ADDR_CTRL_A);
        chk("ctrl_a", 16'h05, {8'h0, d});
        wait_lol(1'b0, 5 * WIN);
        chk("osc_hi", 16'h1, {15'h0, osc_code >= 16'h0100});
    endtask : t_ref

    // ==========================================================
    // Main sequence
    initial begin
        clock = 1'b0;
        sys_rst = 1'b1;
        addr = 4'h0;
        wdata = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        bit_ns = 8'd16;
        amp_low = 1'b0;
        n_errors = 0;
        tests_run = 0;
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        settle(1);
        t_reset();
        t_regs();
        t_signal();
        t_lock();
        t_lose();
        t_sticky();
        t_ref();
        end_sim();
    end
endmodule : cld_lock_detector_bench
`default_nettype wire
